// ---- dv/stim_osc_model.sv ----
// Purpose: free-running stand-ins for the on-chip oscillators
// Assumes: every source stays below clk/2
// Notes: odd periods keep edges off the clk grid
`timescale 1ns/1ps
module stim_osc_model (
	// oscillator outputs
	output logic highRcClk = 1'b0,
	output logic extOscClk = 1'b0,
	output logic lowRcClk = 1'b0
);
	always #100.3 highRcClk = ~highRcClk;
	always #200.7 extOscClk = ~extOscClk;
	always #500.9 lowRcClk = ~lowRcClk;
endmodule

// ---- dv/stim_timer_chk.sv ----
// Purpose: port checker for stim_timer
// Assumes: one clock, async active-low reset
// Notes: bound below the module
`timescale 1ns/1ps
`include "stim_defs.svh"
module stim_timer_chk (
	// clock, reset, register port
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	// pins and counter
	input wire logic [7:0] portAPins,
	input wire logic [7:0] portADigitalIn,
	input wire logic [15:0] timerCount
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// quiet cycles so a later mode write cannot blur the check
	sequence s_modeQuiet(logic [4:0] top);
		regWrStb && regAddr == `STIM_OFF_TIMER_MODE && regWrData[7:3] == top ##1 !regWrStb [*3];
	endsequence
	sequence s_rdAt(logic [7:0] a);
		regRdStb && regAddr == a;
	endsequence
	property p_rdIdle;
		!regRdStb |=> regRdData == 8'h00;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("idle read data");
	property p_countStep;
		$changed(timerCount) |-> timerCount == $past(timerCount) + 16'h0001;
	endproperty
	a_countStep: assert property (p_countStep) else $error("count step");
	property p_stop;
		s_modeQuiet(5'h00) |=> $stable(timerCount);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped count moved");
	property p_sysCount;
		s_modeQuiet(5'h04) |=> timerCount == $past(timerCount) + 16'h0001;
	endproperty
	a_sysCount: assert property (p_sysCount) else $error("system clock count");
	property p_zeroRead;
		s_rdAt(`STIM_OFF_EDGE_SEL) or s_rdAt(`STIM_OFF_IN_EN) or s_rdAt(8'h30) |=> regRdData == 8'h00;
	endproperty
	a_zeroRead: assert property (p_zeroRead) else $error("write-only read");
	property p_cntLo;
		s_rdAt(`STIM_OFF_COUNT_LO) |=> regRdData == 8'($past(timerCount));
	endproperty
	a_cntLo: assert property (p_cntLo) else $error("count low read");
	property p_cntHi;
		s_rdAt(`STIM_OFF_COUNT_HI) |=> regRdData == 8'($past(timerCount) >> 8);
	endproperty
	a_cntHi: assert property (p_cntHi) else $error("count high read");
	property p_inGate;
		$stable(portAPins) [*4] |-> (portADigitalIn & ~portAPins) == 8'h00;
	endproperty
	a_inGate: assert property (p_inGate) else $error("input gating");
endmodule
bind stim_timer stim_timer_chk chk_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .portAPins(portAPins),
	.portADigitalIn(portADigitalIn), .timerCount(timerCount));

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for stim_timer
// Assumes: 40 MHz clk, oscillators from stim_osc_model
// Notes: pins driven by the bench directly
`timescale 1ns/1ps
`include "stim_defs.svh"
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] portAPins = 8'h00;
	logic [7:0] regRdData, portADigitalIn;
	logic [15:0] timerCount, c0, cnt;
	logic highRcClk, extOscClk, lowRcClk, wakeReq, irq;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	stim_osc_model osc_u (.highRcClk(highRcClk), .extOscClk(extOscClk), .lowRcClk(lowRcClk));
	stim_timer dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData), .portAPins(portAPins), .highRcClk(highRcClk),
		.extOscClk(extOscClk), .lowRcClk(lowRcClk), .portADigitalIn(portADigitalIn), .wakeReq(wakeReq),
		.irq(irq), .timerCount(timerCount));
	task automatic finish_test();
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// run needs about 7k cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk(input string w, input int lo, input int hi, input logic [15:0] got);
		n_tests++;
		if ((^got) === 1'bx || got < lo || got > hi) begin
			miscompares++;
			$display("wrong value %s expected %0d..%0d seen %0d", w, lo, hi, got);
		end
	endtask
	// sample 1ns after the edge so outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input int e, input string w);
		@(posedge clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk);
		regRdStb <= 1'b0;
		#1;
		chk(w, e, e, regRdData);
	endtask
	task automatic pins(input logic [7:0] v);
		@(posedge clk);
		portAPins <= v;
		wt(4);
	endtask
	function automatic int hit(input int c, input int v);
		return c == 0 || c == (v ? 1 : 2);
	endfunction
	task automatic t_count();
		logic [7:0] md[9] = '{8'h20, 8'h28, 8'h30, 8'h38, 8'h00, 8'h40, 8'h80, 8'hA0, 8'hC0};
		int lo[9] = '{256, 64, 16, 4, 0, 0, 30, 15, 5};
		int hi[9] = '{256, 64, 16, 4, 0, 0, 33, 17, 7};
		rdc(`STIM_OFF_IRQ_EN, 0, "enable reset");
		for (int k = 0; k < 9; k++) begin
			wr(`STIM_OFF_TIMER_MODE, md[k]);
			wt(3);
			c0 = timerCount;
			wt(256);
			chk("count rate", lo[k], hi[k], timerCount - c0);
		end
		rdc(`STIM_OFF_TIMER_MODE, 8'hC0, "mode read");
		wr(`STIM_OFF_TIMER_MODE, 8'h00);
		wr(`STIM_OFF_COUNT_LO, 8'h55);
		wt(4);
		c0 = timerCount;
		rdc(`STIM_OFF_COUNT_LO, c0[7:0], "count low");
		rdc(`STIM_OFF_COUNT_HI, c0[15:8], "count high");
		rdc(`STIM_OFF_IN_EN, 0, "write-only read");
		rdc(8'h30, 0, "unmapped read");
	endtask
	task automatic t_pincnt();
		for (int k = 0; k < 4; k++) begin
			wr(`STIM_OFF_IN_EN, k[0] ? 8'hE8 : 8'hF9);
			wr(`STIM_OFF_TIMER_MODE, k[1] ? 8'hE0 : 8'h60);
			wt(3);
			c0 = timerCount;
			repeat (3) begin
				pins(k[1] ? 8'h01 : 8'h10);
				pins(8'h00);
			end
			chk("pin count", k[0] ? 0 : 3, k[0] ? 0 : 3, timerCount - c0);
		end
	endtask
	task automatic t_pinirq();
		int e;
		wr(`STIM_OFF_TIMER_MODE, 8'h00);
		wr(`STIM_OFF_IN_EN, 8'hF9);
		wr(`STIM_OFF_IRQ_EN, 8'h03);
		for (int k = 0; k < 4; k++) begin
			wr(`STIM_OFF_EDGE_SEL, 8'(k * 4 + 3 - k));
			for (int v = 1; v >= 0; v--) begin
				wr(`STIM_OFF_IRQ_REQ, 8'h07);
				pins(v ? 8'h11 : 8'h00);
				e = hit(k, v) * 2 + hit(3 - k, v);
				rdc(`STIM_OFF_IRQ_REQ, e, "pin request");
				chk("pin irq", e != 0, e != 0, irq);
			end
		end
		wr(`STIM_OFF_EDGE_SEL, 8'h00);
		wr(`STIM_OFF_IN_EN, 8'hE8);
		wr(`STIM_OFF_IRQ_REQ, 8'h07);
		pins(8'h11);
		pins(8'h00);
		rdc(`STIM_OFF_IRQ_REQ, 0, "gated request");
		wr(`STIM_OFF_IN_EN, 8'hF9);
	endtask
	task automatic t_timirq();
		int s;
		for (int k = 0; k < 4; k++) begin
			s = k[1] ? 2 : 0;
			wr(`STIM_OFF_TIMER_MODE, 8'h00);
			wr(`STIM_OFF_EDGE_SEL, k[0] ? 8'h10 : 8'h00);
			wr(`STIM_OFF_IRQ_EN, 8'h04);
			wr(`STIM_OFF_IRQ_REQ, 8'h07);
			wr(`STIM_OFF_TIMER_MODE, 8'(8'h20 + s));
			wt(1);
			for (int n = 0; n < 3000 && irq !== 1'b1; n++)
				wt(1);
			chk("timer bit", !k[0], !k[0], timerCount[8 + s]);
			chk("timer low", 0, 0, timerCount & ((16'h0001 << (8 + s)) - 16'h0001));
			wr(`STIM_OFF_IRQ_EN, 8'h00);
			rdc(`STIM_OFF_IRQ_REQ, 8'h04, "timer request");
			chk("masked irq", 0, 0, irq);
			wr(`STIM_OFF_IRQ_REQ, 8'h04);
			rdc(`STIM_OFF_IRQ_REQ, 0, "request clear");
		end
	endtask
	task automatic t_wake();
		logic [7:0] en[3] = '{8'hF9, 8'h39, 8'h00};
		int x;
		for (int k = 0; k < 3; k++) begin
			wr(`STIM_OFF_IN_EN, en[k]);
			for (int b = 0; b < 8; b++) begin
				@(posedge clk);
				portAPins <= 8'h01 << b;
				cnt = 0;
				repeat (6) begin
					wt(1);
					cnt = cnt + wakeReq;
				end
				x = en[k][b] && b != 1 && b != 2;
				chk("wake", x, x, cnt);
				chk("digital in", en[k] & (8'h01 << b), en[k] & (8'h01 << b), portADigitalIn);
				pins(8'h00);
				wt(3);
			end
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_count();
		t_pincnt();
		t_pinirq();
		t_timirq();
		t_wake();
		finish_test();
	end
endmodule

// ---- hw/stim_defs.svh ----
// Purpose: offsets, field positions and reset values of the timer and pin interrupt block
// Assumes: 8-bit register port, 8-bit addresses
// Notes: definitions only
`ifndef STIM_DEFS_SVH
`define STIM_DEFS_SVH

`define STIM_OFF_IRQ_EN 8'h04
`define STIM_OFF_IRQ_REQ 8'h05
`define STIM_OFF_TIMER_MODE 8'h06
`define STIM_OFF_EDGE_SEL 8'h0C
`define STIM_OFF_IN_EN 8'h0D
`define STIM_OFF_COUNT_LO 8'h20
`define STIM_OFF_COUNT_HI 8'h21

`define STIM_RST_TIMER_MODE 8'h00
`define STIM_RST_EDGE_SEL 8'h00
`define STIM_RST_IN_EN 8'hFF
`define STIM_RST_IRQ_EN 3'h0
`define STIM_RST_IRQ_REQ 3'h0

`define STIM_IRQ_PIN_ZERO 0
`define STIM_IRQ_PIN_ONE 1
`define STIM_IRQ_TIMER 2

`define STIM_PIN_ZERO 0
`define STIM_PIN_FOUR 4
`define STIM_WAKE_MASK 8'hF9

`define STIM_TIMER_SEL_BASE 8
`define STIM_PRE_MASK_1 6'h00
`define STIM_PRE_MASK_4 6'h03
`define STIM_PRE_MASK_16 6'h0F
`define STIM_PRE_MASK_64 6'h3F

`define STIM_SYNC_WIDTH 11

`endif

// ---- hw/stim_pkg.sv ----
// Purpose: types of the timer and pin interrupt block
// Assumes: field layout as in stim_defs.svh
// Notes: struct member order follows the register bit order
package stim_pkg;

	typedef enum logic [2:0] {
		STIM_CLK_OFF = 3'h0,
		STIM_CLK_SYS = 3'h1,
		STIM_CLK_RSVD = 3'h2,
		STIM_CLK_PIN_FOUR = 3'h3,
		STIM_CLK_HIGH_RC = 3'h4,
		STIM_CLK_EXT_OSC = 3'h5,
		STIM_CLK_LOW_RC = 3'h6,
		STIM_CLK_PIN_ZERO = 3'h7
	} stim_clk_sel_t;

	typedef enum logic [1:0] {
		STIM_PRE_1 = 2'h0,
		STIM_PRE_4 = 2'h1,
		STIM_PRE_16 = 2'h2,
		STIM_PRE_64 = 2'h3
	} stim_pre_t;

	typedef enum logic [1:0] {
		STIM_EDGE_BOTH = 2'h0,
		STIM_EDGE_RISE = 2'h1,
		STIM_EDGE_FALL = 2'h2,
		STIM_EDGE_RSVD = 2'h3
	} stim_edge_t;

	// timer_mode layout
	typedef struct packed {
		stim_clk_sel_t clkSel;
		stim_pre_t preDiv;
		logic [2:0] irqBit;
	} stim_mode_t;

	// interrupt_edge_select layout
	typedef struct packed {
		logic [2:0] unused;
		logic timerFall;
		stim_edge_t pinOneEdge;
		stim_edge_t pinZeroEdge;
	} stim_edge_sel_t;

endpackage

// ---- hw/stim_sync.sv ----
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: inputs slower than half the clock rate when edges matter
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module stim_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= asyncIn[i];
					sync_reg <= meta_reg;
				end
			end
			assign syncOut[i] = sync_reg;
		end
	endgenerate

endmodule

// ---- hw/stim_timer.sv ----
// Purpose: 16-bit timer with source select, prescaler, bit-edge interrupt, pin interrupts and port A input enables
// Assumes: oscillator sources and pins are asynchronous and sampled on clk; each must stay below clk/2
// Notes: registers on an 8-bit strobe port, read data one cycle after the read strobe
`timescale 1ns/1ps
`include "stim_defs.svh"

// Notes on behaviour
// - source field selects stop, system, RC, oscillator
// - codes 011/111 count falling pin edges
// - interrupt watches counter bit eight plus field
// - edge bit picks rising or falling transition
// - pin-one edge: both, rising, falling, none
// - pin-zero edge: both, rising, falling, none
// - enables seven/six gate input and wake-up
// - enable five gates input and wake-up
// - enable four gates input, wake, interrupt
// - enable three gates input and wake-up
// - enable zero gates input, wake, interrupt
// - timer event sets request flag bit two
// - enable bit two passes timer request
// - pin-one edge sets request flag bit one
module stim_timer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	// port A pins and oscillator sources
	input wire logic [7:0] portAPins,
	input wire logic highRcClk,
	input wire logic extOscClk,
	input wire logic lowRcClk,
	// results
	output logic [7:0] portADigitalIn,
	output logic wakeReq,
	output logic irq,
	output logic [15:0] timerCount
);

	stim_pkg::stim_mode_t mode_reg;
	stim_pkg::stim_edge_sel_t edgeSel_reg;
	logic [7:0] inEnable_reg;
	logic [2:0] irqEn_reg;
	logic [2:0] irqReq_reg;
	logic [2:0] irqReq_next;
	logic [15:0] count_reg;
	logic [15:0] countNext;
	logic [5:0] preCnt_reg;
	logic [5:0] preMask;
	logic [7:0] rdData_reg;
	logic [7:0] rdValue;
	logic [7:0] pinsPrev_reg;
	logic [7:0] gatedIn_reg;
	logic wake_reg;
	logic [2:0] oscPrev_reg;
	logic [`STIM_SYNC_WIDTH-1:0] syncIn;
	logic [7:0] pinsNow;
	logic [2:0] oscNow;
	logic srcTick;
	logic preTick;
	logic oldBit;
	logic newBit;
	logic timerEvent;
	logic pinZeroEvent;
	logic pinOneEvent;
	logic wrHit;

	// 00 both, 01 rising, 10 falling, 11 never
	function automatic logic edgeHit(input logic prev, input logic cur, input stim_pkg::stim_edge_t sel);
		logic hit;
		hit = 1'b0;
		case (sel)
			stim_pkg::STIM_EDGE_BOTH: hit = prev ^ cur;
			stim_pkg::STIM_EDGE_RISE: hit = !prev && cur;
			stim_pkg::STIM_EDGE_FALL: hit = prev && !cur;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	stim_sync #(
		.WIDTH(`STIM_SYNC_WIDTH)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn({lowRcClk, extOscClk, highRcClk, portAPins}),
		.syncOut(syncIn)
	);

	assign pinsNow = syncIn[7:0];
	assign oscNow = syncIn[10:8];

	// previous pin samples for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinsPrev_reg <= 8'h00;
		end else begin
			pinsPrev_reg <= pinsNow;
		end
	end

	// previous oscillator samples, reset low like the sync flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oscPrev_reg <= 3'h0;
		end else begin
			oscPrev_reg <= oscNow;
		end
	end

	// source tick, one cycle per selected edge
	always_comb begin
		srcTick = 1'b0;
		case (mode_reg.clkSel)
			stim_pkg::STIM_CLK_OFF: srcTick = 1'b0;
			stim_pkg::STIM_CLK_SYS: srcTick = 1'b1;
			// falling edge of enabled pin four
			stim_pkg::STIM_CLK_PIN_FOUR: srcTick = inEnable_reg[`STIM_PIN_FOUR] &&
				pinsPrev_reg[`STIM_PIN_FOUR] && !pinsNow[`STIM_PIN_FOUR];
			stim_pkg::STIM_CLK_HIGH_RC: srcTick = !oscPrev_reg[0] && oscNow[0];
			stim_pkg::STIM_CLK_EXT_OSC: srcTick = !oscPrev_reg[1] && oscNow[1];
			stim_pkg::STIM_CLK_LOW_RC: srcTick = !oscPrev_reg[2] && oscNow[2];
			// falling edge of enabled pin zero
			stim_pkg::STIM_CLK_PIN_ZERO: srcTick = inEnable_reg[`STIM_PIN_ZERO] &&
				pinsPrev_reg[`STIM_PIN_ZERO] && !pinsNow[`STIM_PIN_ZERO];
			default: srcTick = 1'b0;
		endcase
	end

	always_comb begin
		preMask = `STIM_PRE_MASK_1;
		case (mode_reg.preDiv)
			stim_pkg::STIM_PRE_1: preMask = `STIM_PRE_MASK_1;
			stim_pkg::STIM_PRE_4: preMask = `STIM_PRE_MASK_4;
			stim_pkg::STIM_PRE_16: preMask = `STIM_PRE_MASK_16;
			stim_pkg::STIM_PRE_64: preMask = `STIM_PRE_MASK_64;
			default: preMask = `STIM_PRE_MASK_1;
		endcase
	end

	// prescaler keeps its phase across mode writes, so the first period may be short
	assign preTick = srcTick && ((preCnt_reg & preMask) == preMask);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			preCnt_reg <= 6'h00;
		end else if (srcTick) begin
			preCnt_reg <= preCnt_reg + 6'h01;
		end
	end

	// wraps from all ones to zero
	assign countNext = count_reg + 16'h0001;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 16'h0000;
		end else if (preTick) begin
			// advance by one per prescaled tick
			count_reg <= countNext;
		end
	end

	// compared across the tick itself, so changing the bit select cannot fake an event
	always_comb begin
		oldBit = count_reg[`STIM_TIMER_SEL_BASE + mode_reg.irqBit];
		newBit = countNext[`STIM_TIMER_SEL_BASE + mode_reg.irqBit];
		// rising when 0, falling when 1
		timerEvent = preTick && (edgeSel_reg.timerFall ? (oldBit && !newBit) : (!oldBit && newBit));
	end

	// pin zero edge, gated by its enable
	assign pinZeroEvent = inEnable_reg[`STIM_PIN_ZERO] &&
		edgeHit(pinsPrev_reg[`STIM_PIN_ZERO], pinsNow[`STIM_PIN_ZERO], edgeSel_reg.pinZeroEdge);
	// pin one edge, gated by its enable
	assign pinOneEvent = inEnable_reg[`STIM_PIN_FOUR] &&
		edgeHit(pinsPrev_reg[`STIM_PIN_FOUR], pinsNow[`STIM_PIN_FOUR], edgeSel_reg.pinOneEdge);

	assign wrHit = regWrStb && (regAddr == `STIM_OFF_IRQ_REQ);

	// write-one-to-clear, but a set in the same cycle wins
	always_comb begin
		irqReq_next = irqReq_reg;
		if (wrHit) begin
			irqReq_next = irqReq_reg & ~regWrData[2:0];
		end
		if (timerEvent) begin
			irqReq_next[`STIM_IRQ_TIMER] = 1'b1;
		end
		// pin one edge sets bit one
		if (pinOneEvent) begin
			irqReq_next[`STIM_IRQ_PIN_ONE] = 1'b1;
		end
		if (pinZeroEvent) begin
			irqReq_next[`STIM_IRQ_PIN_ZERO] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqReq_reg <= `STIM_RST_IRQ_REQ;
		end else begin
			irqReq_reg <= irqReq_next;
		end
	end

	// configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= `STIM_RST_TIMER_MODE;
			edgeSel_reg <= `STIM_RST_EDGE_SEL;
			inEnable_reg <= `STIM_RST_IN_EN;
			irqEn_reg <= `STIM_RST_IRQ_EN;
		end else if (regWrStb) begin
			case (regAddr)
				`STIM_OFF_TIMER_MODE: mode_reg <= regWrData;
				`STIM_OFF_EDGE_SEL: edgeSel_reg <= {3'h0, regWrData[4:0]};
				`STIM_OFF_IN_EN: inEnable_reg <= regWrData;
				`STIM_OFF_IRQ_EN: irqEn_reg <= regWrData[2:0];
				default: begin
				end
			endcase
		end
	end

	// only enabled requests reach the output
	assign irq = |(irqReq_reg & irqEn_reg);

	// write-only registers read back zero
	always_comb begin
		rdValue = 8'h00;
		case (regAddr)
			`STIM_OFF_TIMER_MODE: rdValue = mode_reg;
			`STIM_OFF_IRQ_EN: rdValue = {5'h00, irqEn_reg};
			`STIM_OFF_IRQ_REQ: rdValue = {5'h00, irqReq_reg};
			`STIM_OFF_COUNT_LO: rdValue = count_reg[7:0];
			`STIM_OFF_COUNT_HI: rdValue = count_reg[15:8];
			default: rdValue = 8'h00;
		endcase
	end

	// data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 8'h00;
		end else if (regRdStb) begin
			rdData_reg <= rdValue;
		end else begin
			rdData_reg <= 8'h00;
		end
	end

	assign regRdData = rdData_reg;

	// gated digital input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gatedIn_reg <= 8'h00;
		end else begin
			gatedIn_reg <= pinsNow & inEnable_reg;
		end
	end

	// wake-up pulse, reserved bits two and one never wake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= |((pinsNow ^ pinsPrev_reg) & inEnable_reg & `STIM_WAKE_MASK);
		end
	end

	// enable toggles compare raw samples, so clearing an enable never looks like an edge
	assign portADigitalIn = gatedIn_reg;
	assign wakeReq = wake_reg;
	assign timerCount = count_reg;

endmodule
